// file: bfr_boot_ctrl.sv
// boot controller: fast autoboot, boot assist, failure report, soft reset
`timescale 1ns/100ps
`default_nettype none

`include "bfr_consts.svh"

module bfr_boot_ctrl import bfr_pkg::*; #(
	parameter logic [15:0] FETCH_BYTES = `BFR_FETCH_LEN
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// shared select / attention pin and mode straps
	input wire logic autoboot_select_n,
	output logic host_attention_n,
	output logic host_attention_n_en,
	input wire logic [1:0] mode_strap,
	// external memory pins
	output logic memory_output_enable_strobe_n,
	output logic ext_memory_select_n,
	input wire logic [7:0] mem_data_pin,
	output logic [7:0] mem_data_drive,
	output logic mem_data_en,
	// serial port side
	input wire logic msg_valid,
	input wire logic [23:0] msg_word,
	input wire logic image_valid,
	input wire logic image_last,
	input wire logic image_sum_ok,
	input wire logic [2:0] image_kind,
	input wire logic image_fits,
	input wire logic reply_read,
	input wire logic app_resident,
	// replies and core controls
	output logic reply_ready,
	output logic [7:0] reply_byte,
	output logic [3:0] core_div,
	output logic pll_lock,
	output logic app_run,
	output logic internal_app_enable,
	output logic config_default,
	output logic code_valid,
	output logic [7:0] code_byte
);

	bfr_ctrl_t q, d;
	bfr_fetch_if fx ();

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.cfg_def = 1'b0;
		d.start = 1'b0;
		// pins pass three flops; only the third and second are compared
		d.sy_a = {autoboot_select_n, mode_strap};
		d.sy_b = q.sy_a;
		d.sy_c = q.sy_b;
		// fetched code bytes go straight to the core
		d.code_v = fx.bv;
		d.code_b = fx.bd;
		// a read takes the reply; a new reply below wins over it
		if (reply_read) begin
			d.rdy = 1'b0;
		end
		case (q.st)
			ST_STRAP: begin
				if (q.settle != `BFR_SETTLE) begin
					d.settle = q.settle + 2'h1;
				// strap decision once the pins agree
				end else if (q.sy_b == q.sy_c) begin
					if (!q.sy_c[2] && q.sy_c[1:0] != `BFR_MODE_PARALLEL) begin
						d.div = `BFR_DIV_STD;
						d.start = 1'b1;
						d.st = ST_FETCH;
					end else begin
						d.st = ST_CMD;
					end
				end
			end
			ST_CMD: begin
				if (msg_valid) begin
					// download request answered with ready byte
					if (msg_word == `BFR_MSG_DOWNLOAD) begin
						d.rdy = 1'b1;
						d.rbyte = `BFR_RPL_START;
						d.st = ST_LOAD;
					// soft reset restarts with default settings
					end else if (msg_word == `BFR_MSG_SOFT_RESET
						&& app_resident) begin
						d.cfg_def = 1'b1;
						d.app_run = 1'b1;
						d.st = ST_RUN;
					end else if (msg_word == `BFR_MSG_PLL_LOCK) begin
						d.pll_lock = 1'b1;
					end
				end
			end
			ST_LOAD: begin
				if (image_valid && image_last) begin
					if (!image_sum_ok) begin
						d.rdy = 1'b1;
						d.rbyte = `BFR_RPL_BAD_SUM;
						d.st = ST_HALT;
					end else begin
						d.rdy = 1'b1;
						d.rbyte = `BFR_RPL_OK;
						case (image_kind)
							// fast loader leads straight into autoboot
							`BFR_KIND_FAST8, `BFR_KIND_FAST6,
							`BFR_KIND_FAST4: begin
								d.start = 1'b1;
								d.st = ST_FETCH;
								if (image_kind == `BFR_KIND_FAST8) begin
									d.div = `BFR_DIV_FAST8;
								end else if (image_kind == `BFR_KIND_FAST6) begin
									d.div = `BFR_DIV_FAST6;
								end else begin
									d.div = `BFR_DIV_FAST4;
								end
							end
							// boot assist enables internal rom code
							`BFR_KIND_ASSIST: begin
								d.iba_en = 1'b1;
								d.st = ST_RUN;
							end
							default: d.st = ST_ACK;
						endcase
					end
				end
			end
			ST_ACK: begin
				if (msg_valid && msg_word == `BFR_MSG_DL_ACK) begin
					if (image_fits) begin
						d.app_run = 1'b1;
					end else begin
						// failure byte for the host to read
						d.rdy = 1'b1;
						d.rbyte = `BFR_RPL_APP_FAIL;
					end
					d.st = ST_RUN;
				end
			end
			ST_FETCH: begin
				if (fx.done) begin
					if (image_fits) begin
						d.app_run = 1'b1;
					end else begin
						d.rdy = 1'b1;
						d.rbyte = `BFR_RPL_APP_FAIL;
					end
					d.st = ST_RUN;
				end
			end
			ST_RUN: begin
				// lock may come later with the start of decoding
				if (msg_valid && msg_word == `BFR_MSG_PLL_LOCK) begin
					d.pll_lock = 1'b1;
				end
			end
			default: d.st = ST_HALT; // spins until hard reset
		endcase
		// pin left released while straps settle and during a fetch
		d.attn_en = d.rdy && d.st != ST_FETCH && d.st != ST_STRAP;
		d.attn_n = ~d.attn_en;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
			q.div <= `BFR_DIV_STD;
			q.attn_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// fetch engine
	// ----------------------------------------------------------------
	assign fx.start = q.start;
	assign fx.div = q.div;
	assign fx.len = FETCH_BYTES;

	bfr_rom_fetch u_fetch (
		.clk(clk),
		.rst(rst),
		.fx(fx),
		.strobe_n(memory_output_enable_strobe_n),
		.sel_n(ext_memory_select_n),
		.dout(mem_data_drive),
		.den(mem_data_en),
		.din(mem_data_pin)
	);

	// outputs straight from the state register
	assign host_attention_n = q.attn_n;
	assign host_attention_n_en = q.attn_en;
	assign reply_ready = q.rdy;
	assign reply_byte = q.rbyte;
	assign core_div = q.div;
	assign pll_lock = q.pll_lock;
	assign app_run = q.app_run;
	assign internal_app_enable = q.iba_en;
	assign config_default = q.cfg_def;
	assign code_valid = q.code_v;
	assign code_byte = q.code_b;

endmodule : bfr_boot_ctrl

`default_nettype wire

// file: bfr_boot_ctrl_bench.sv
// self-checking bench for the boot controller
`timescale 1ns/100ps
`default_nettype none

module bfr_boot_ctrl_bench;
	logic clk = 1'b0, rst = 1'b1, sel_drv = 1'b1, mv = 1'b0, iv = 1'b0;
	logic il = 1'b0, iok = 1'b0, fits = 1'b0, rdr = 1'b0, res = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [23:0] mw = 24'h000000;
	logic [2:0] ik = 3'h0;
	logic attn_n, attn_en, strb_n, msel_n, den, rr, pll, run, iae, cfg, cv;
	logic [7:0] ddrv, rb, cb, rom_d;
	logic [3:0] div;
	int n_errors = 0;
	int cmp_count = 0;
	// open-drain select pin with pull-up, shared data pins
	wire logic abs_n = attn_en ? 1'b0 : sel_drv;
	wire logic [7:0] pin = den ? ddrv : rom_d;

	always #2.5 clk = ~clk;

	bfr_boot_ctrl #(.FETCH_BYTES(16'h0004)) dut_u (
		.clk(clk), .rst(rst), .autoboot_select_n(abs_n),
		.host_attention_n(attn_n), .host_attention_n_en(attn_en),
		.mode_strap(mode), .memory_output_enable_strobe_n(strb_n),
		.ext_memory_select_n(msel_n), .mem_data_pin(pin),
		.mem_data_drive(ddrv), .mem_data_en(den), .msg_valid(mv),
		.msg_word(mw), .image_valid(iv), .image_last(il),
		.image_sum_ok(iok), .image_kind(ik), .image_fits(fits),
		.reply_read(rdr), .app_resident(res), .reply_ready(rr),
		.reply_byte(rb), .core_div(div), .pll_lock(pll), .app_run(run),
		.internal_app_enable(iae), .config_default(cfg),
		.code_valid(cv), .code_byte(cb));
	bfr_rom_model rom_u (.rst(rst), .strobe_n(strb_n), .sel_n(msel_n),
		.pin(pin), .rom_d(rom_d));

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	function automatic logic sig(input int s);
		case (s)
			0: return rr;
			1: return cv;
			default: return run;
		endcase
	endfunction : sig

	// bounded wait for reply, code byte or start
	task automatic wt(input int s, input int n);
		int i;
		#1;
		for (i = 0; i < n && sig(s) !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (sig(s) !== 1'b1) begin
			n_errors++;
			$display("mismatch wait %0d expected 1 seen 0", s);
			report_and_stop();
		end
	endtask : wt

	task automatic boot(input logic s);
		@(posedge clk);
		rst <= 1'b1;
		sel_drv <= s;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		sel_drv <= 1'b1;
	endtask : boot

	task automatic send(input logic [23:0] w);
		@(posedge clk);
		mv <= 1'b1;
		mw <= w;
		@(posedge clk);
		mv <= 1'b0;
	endtask : send

	task automatic rd(input logic [7:0] e);
		wt(0, 300);
		chk("reply_byte", e, rb);
		@(posedge clk);
		rdr <= 1'b1;
		@(posedge clk);
		rdr <= 1'b0;
	endtask : rd

	task automatic img(input logic [2:0] k, input logic ok);
		@(posedge clk);
		iv <= 1'b1;
		il <= 1'b1;
		iok <= ok;
		ik <= k;
		@(posedge clk);
		iv <= 1'b0;
		il <= 1'b0;
	endtask : img

	task automatic fetch_chk();
		int b;
		for (b = 0; b < 4; b++) begin
			wt(1, 1500);
			chk("code_byte", b[7:0] ^ 8'ha5, cb);
			@(posedge clk);
		end
	endtask : fetch_chk

	task automatic t_auto();
		fits <= 1'b0;
		boot(1'b0);
		chk("core_div", 8'h0c, {4'h0, div});
		fetch_chk();
		wt(0, 300);
		chk("host_attention_n", 8'h00, {7'h0, attn_n});
		rd(8'hf0);
		chk("app_run", 8'h00, {7'h0, run});
		$display("test autoboot done");
	endtask : t_auto

	task automatic t_fast(input logic [2:0] k, input logic [3:0] d);
		fits <= 1'b1;
		boot(1'b1);
		send(24'h000004);
		rd(8'h01);
		img(k, 1'b1);
		#1;
		chk("core_div", {4'h0, d}, {4'h0, div});
		chk("host_attention_n", 8'h01, {7'h0, attn_n});
		rd(8'h02);
		fetch_chk();
		wt(2, 50);
		chk("pll_lock", 8'h00, {7'h0, pll});
		send(24'h000006);
		#1;
		chk("pll_lock", 8'h01, {7'h0, pll});
		$display("test fast loader done");
	endtask : t_fast

	task automatic t_app(input logic f);
		fits <= f;
		boot(1'b1);
		send(24'h000004);
		rd(8'h01);
		img(3'h0, 1'b1);
		rd(8'h02);
		send(24'h000005);
		if (f) begin
			wt(2, 20);
		end else begin
			wt(0, 300);
			chk("host_attention_n", 8'h00, {7'h0, attn_n});
			rd(8'hf0);
		end
		chk("app_run", {7'h0, f}, {7'h0, run});
		$display("test application done");
	endtask : t_app

	task automatic t_misc();
		// parallel straps refuse autoboot even with select low
		mode <= 2'h3;
		boot(1'b0);
		send(24'h000004);
		rd(8'h01);
		chk("core_div", 8'h0c, {4'h0, div});
		mode <= 2'h0;
		boot(1'b1);
		send(24'h000004);
		rd(8'h01);
		img(3'h1, 1'b1);
		rd(8'h02);
		chk("internal_app_enable", 8'h01, {7'h0, iae});
		res <= 1'b0;
		boot(1'b1);
		send(24'h000001);
		#1;
		chk("config_default", 8'h00, {7'h0, cfg});
		res <= 1'b1;
		send(24'h000001);
		#1;
		chk("config_default", 8'h01, {7'h0, cfg});
		chk("app_run", 8'h01, {7'h0, run});
		boot(1'b1);
		send(24'h000004);
		rd(8'h01);
		img(3'h0, 1'b0);
		rd(8'hff);
		send(24'h000004);
		repeat (5) @(posedge clk);
		#1;
		chk("reply_ready", 8'h00, {7'h0, rr});
		$display("test assist soft reset checksum done");
	endtask : t_misc

	// hosts here send no configuration later
	initial begin
		t_auto();
		t_fast(3'h2, 4'h8);
		t_fast(3'h3, 4'h6);
		t_fast(3'h4, 4'h4);
		t_app(1'b0);
		t_app(1'b1);
		t_misc();
		report_and_stop();
	end
endmodule : bfr_boot_ctrl_bench

`default_nettype wire

// file: bfr_boot_props.sv
// port checker for the boot controller
`timescale 1ns/100ps
`default_nettype none

module bfr_boot_props #(
	parameter logic [15:0] FETCH_BYTES = 16'h8000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins
	input wire logic host_attention_n,
	input wire logic host_attention_n_en,
	input wire logic memory_output_enable_strobe_n,
	input wire logic ext_memory_select_n,
	input wire logic mem_data_en,
	// host side
	input wire logic msg_valid,
	input wire logic [23:0] msg_word,
	input wire logic image_valid,
	input wire logic image_last,
	input wire logic app_resident,
	input wire logic reply_ready,
	input wire logic [7:0] reply_byte,
	// core controls
	input wire logic [3:0] core_div,
	input wire logic pll_lock,
	input wire logic app_run,
	input wire logic config_default
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_RST_VAL: assert property ($past(rst) |-> core_div == 4'hc
		&& !pll_lock && !app_run) else $error("reset values wrong");
	AST_DIV_SET: assert property ($changed(core_div) && !$past(rst)
		|-> core_div inside {4'h8, 4'h6, 4'h4}) else $error("bad div");
	AST_PLL_CMD: assert property ($rose(pll_lock)
		|-> $past(msg_valid && msg_word == 24'h000006)) else $error("pll");
	AST_DL_START: assert property ($rose(reply_ready) && reply_byte == 8'h01
		|-> $past(msg_valid && msg_word == 24'h000004)) else $error("start");
	AST_DL_OK: assert property ($rose(reply_ready) && reply_byte == 8'h02
		|-> $past(image_valid && image_last)) else $error("ok reply");
	AST_SOFT: assert property (config_default |-> $past(msg_valid
		&& msg_word == 24'h000001 && app_resident) ##1 !config_default)
		else $error("soft reset pulse");
	AST_FAIL: assert property (reply_ready && reply_byte == 8'hf0
		|-> !app_run) else $error("failed code runs");
	AST_ATTN: assert property ((host_attention_n
		== !host_attention_n_en) && (!host_attention_n_en || reply_ready))
		else $error("attention drive");
	AST_RD_PH: assert property (!ext_memory_select_n
		|-> !memory_output_enable_strobe_n && !mem_data_en)
		else $error("data phase pins");
	AST_NO_ATTN: assert property (!memory_output_enable_strobe_n
		|-> !host_attention_n_en) else $error("attention in fetch");

	// main scenarios
	cover property ($rose(app_run));
	cover property ($rose(pll_lock));
	cover property (config_default);
	cover property (reply_ready && reply_byte == 8'hf0);
endmodule : bfr_boot_props

bind bfr_boot_ctrl bfr_boot_props #(.FETCH_BYTES(FETCH_BYTES)) props_u (
	.clk(clk), .rst(rst), .host_attention_n(host_attention_n),
	.host_attention_n_en(host_attention_n_en),
	.memory_output_enable_strobe_n(memory_output_enable_strobe_n),
	.ext_memory_select_n(ext_memory_select_n), .mem_data_en(mem_data_en),
	.msg_valid(msg_valid), .msg_word(msg_word), .image_valid(image_valid),
	.image_last(image_last), .app_resident(app_resident),
	.reply_ready(reply_ready), .reply_byte(reply_byte),
	.core_div(core_div), .pll_lock(pll_lock), .app_run(app_run),
	.config_default(config_default));

`default_nettype wire

// file: bfr_consts.svh
// constant values for the boot controller
`ifndef BFR_CONSTS_SVH
`define BFR_CONSTS_SVH

// ----------------------------------------------------------------
// host message words
// ----------------------------------------------------------------
`define BFR_MSG_SOFT_RESET 24'h000001
`define BFR_MSG_DOWNLOAD 24'h000004
`define BFR_MSG_DL_ACK 24'h000005
`define BFR_MSG_PLL_LOCK 24'h000006

// ----------------------------------------------------------------
// reply bytes
// ----------------------------------------------------------------
`define BFR_RPL_START 8'h01
`define BFR_RPL_OK 8'h02
`define BFR_RPL_BAD_SUM 8'hff
`define BFR_RPL_APP_FAIL 8'hf0

// ----------------------------------------------------------------
// core clock divide factors
// ----------------------------------------------------------------
`define BFR_DIV_STD 4'hc
`define BFR_DIV_FAST8 4'h8
`define BFR_DIV_FAST6 4'h6
`define BFR_DIV_FAST4 4'h4

// ----------------------------------------------------------------
// image kinds, straps, fetch layout
// ----------------------------------------------------------------
`define BFR_KIND_APP 3'h0
`define BFR_KIND_ASSIST 3'h1
`define BFR_KIND_FAST8 3'h2
`define BFR_KIND_FAST6 3'h3
`define BFR_KIND_FAST4 3'h4
`define BFR_MODE_PARALLEL 2'h3
`define BFR_SETTLE 2'h3
`define BFR_FETCH_BASE 24'h000000
`define BFR_FETCH_LEN 16'h8000
`define BFR_PH_DATA 3'h6
`define BFR_PH_LAST 3'h7

`endif

// file: bfr_fetch_if.sv
// link between the boot controller and the rom fetch engine
`timescale 1ns/100ps
`default_nettype none

interface bfr_fetch_if;
	logic start;
	logic [3:0] div;
	logic [15:0] len;
	logic bv;
	logic [7:0] bd;
	logic done;
	modport ctrl (output start, output div, output len,
		input bv, input bd, input done);
	modport eng (input start, input div, input len,
		output bv, output bd, output done);
endinterface : bfr_fetch_if

`default_nettype wire

// file: bfr_pkg.sv
// types shared by the boot controller and its rom fetch engine
`default_nettype none

package bfr_pkg;

	// controller states
	typedef enum logic [2:0] {
		ST_STRAP, ST_CMD, ST_LOAD, ST_ACK, ST_FETCH, ST_RUN, ST_HALT
	} bfr_state_t;

	// fetch engine states
	typedef enum logic {FE_IDLE, FE_BUSY} bfr_fstate_t;

	// all controller state
	typedef struct packed {
		bfr_state_t st;
		logic [2:0] sy_a;
		logic [2:0] sy_b;
		logic [2:0] sy_c;
		logic [1:0] settle;
		logic [3:0] div;
		logic pll_lock;
		logic app_run;
		logic iba_en;
		logic cfg_def;
		logic rdy;
		logic [7:0] rbyte;
		logic attn_en;
		logic attn_n;
		logic start;
		logic code_v;
		logic [7:0] code_b;
	} bfr_ctrl_t;

	// all fetch engine state
	typedef struct packed {
		bfr_fstate_t st;
		logic [3:0] tick;
		logic [3:0] div;
		logic [2:0] ph;
		logic [23:0] addr;
		logic [15:0] left;
		logic [7:0] d_a;
		logic [7:0] d_b;
		logic [7:0] d_c;
		logic strobe_n;
		logic sel_n;
		logic [7:0] dout;
		logic den;
		logic bv;
		logic [7:0] bd;
		logic done;
	} bfr_fetch_t;

endpackage : bfr_pkg

`default_nettype wire

// file: bfr_rom_fetch.sv
// rom fetch engine: address latch cycles and data reads
`timescale 1ns/100ps
`default_nettype none

`include "bfr_consts.svh"

module bfr_rom_fetch import bfr_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// controller side
	bfr_fetch_if.eng fx,
	// memory pins
	output logic strobe_n,
	output logic sel_n,
	output logic [7:0] dout,
	output logic den,
	input wire logic [7:0] din
);

	bfr_fetch_t q, d;

	// address byte for a latch cycle, high byte first
	function automatic logic [7:0] abyte(input logic [23:0] a,
		input logic [1:0] i);
		case (i)
			2'h0: return a[23:16];
			2'h1: return a[15:8];
			default: return a[7:0];
		endcase
	endfunction : abyte

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// each phase lasts div core cycles, the data phase at least div; even phases pull the strobe low
	always_comb begin
		d = q;
		d.bv = 1'b0;
		d.done = 1'b0;
		d.d_a = din;
		d.d_b = q.d_a;
		d.d_c = q.d_b;
		case (q.st)
			FE_IDLE: begin
				if (fx.start) begin
					d.st = FE_BUSY;
					d.div = fx.div;
					d.left = fx.len;
					d.addr = `BFR_FETCH_BASE;
					d.tick = 4'h0;
					d.ph = 3'h0;
					d.strobe_n = 1'b0;
					d.den = 1'b1;
					d.dout = abyte(`BFR_FETCH_BASE, 2'h0);
				end
			end
			FE_BUSY: begin
				if (q.tick != q.div - 4'h1) begin
					d.tick = q.tick + 4'h1;
				// hold the read until the data pins have settled
				end else if (q.ph != `BFR_PH_DATA || q.d_b == q.d_c) begin
					d.tick = 4'h0;
					// data read on fourth low pulse
					if (q.ph == `BFR_PH_DATA) begin
						d.bv = 1'b1;
						d.bd = q.d_c;
						d.strobe_n = 1'b1;
						d.sel_n = 1'b1;
						d.ph = `BFR_PH_LAST;
					end else if (q.ph == `BFR_PH_LAST) begin
						if (q.left == 16'h1) begin
							d.done = 1'b1;
							d.st = FE_IDLE;
						end else begin
							d.left = q.left - 16'h1;
							d.addr = q.addr + 24'h1;
							d.ph = 3'h0;
							d.strobe_n = 1'b0;
							d.den = 1'b1;
							d.dout = abyte(q.addr + 24'h1, 2'h0);
						end
					end else begin
						d.ph = q.ph + 3'h1;
						// rising edges latch the three address bytes
						if (d.ph == `BFR_PH_DATA) begin
							d.sel_n = 1'b0;
							d.strobe_n = 1'b0;
							d.den = 1'b0; // pins turn to inputs
						end else begin
							d.strobe_n = d.ph[0];
							d.dout = abyte(q.addr, d.ph[2:1]);
						end
					end
				end
			end
			default: d.st = FE_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
			q.strobe_n <= 1'b1;
			q.sel_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign strobe_n = q.strobe_n;
	assign sel_n = q.sel_n;
	assign dout = q.dout;
	assign den = q.den;
	assign fx.bv = q.bv;
	assign fx.bd = q.bd;
	assign fx.done = q.done;

endmodule : bfr_rom_fetch

`default_nettype wire

// file: bfr_rom_model.sv
// external rom behind three address latches
`timescale 1ns/100ps
`default_nettype none

module bfr_rom_model (
	// reset and memory pins
	input wire logic rst,
	input wire logic strobe_n,
	input wire logic sel_n,
	input wire logic [7:0] pin,
	output logic [7:0] rom_d
);
	logic [23:0] addr = 24'h000000;
	logic [1:0] cnt = 2'h0;
	logic [7:0] last = 8'h00;

	always @(posedge strobe_n or posedge rst) begin
		if (rst) begin
			cnt <= 2'h0;
		end else begin
			if (cnt != 2'h3) begin
				addr <= {addr[15:0], pin};
			end
			cnt <= cnt + 2'h1;
		end
	end

	// released pins show the inverse of the last byte
	always @(posedge sel_n) begin
		last <= addr[7:0] ^ 8'ha5;
	end

	assign rom_d = (!sel_n && !strobe_n) ? (addr[7:0] ^ 8'ha5) : ~last;
endmodule : bfr_rom_model

`default_nettype wire
